// [design/ipu_pkg.sv]
// Purpose: shared constants and carriers for the integer product unit
// Assumes: 16-bit working registers, 40-bit accumulators
// Notes:   operation codes are local to this unit

package ipu_pkg;

   // ****************************************************************
   // widths and fixed register indices
   // ****************************************************************
   localparam int             WORD_W     = 16;
   localparam int             ACC_W      = 40;
   localparam int             REG_IDX_W  = 4;
   localparam int             LIT_W      = 5;
   localparam int             PROD_W     = 2 * WORD_W;
   localparam logic [3:0]     FIXED_LO   = 4'h2;
   localparam logic [3:0]     FIXED_HI   = 4'h3;
   localparam logic [3:0]     IDX_ONE    = 4'h1;
   localparam logic [1:0]     ACC_COUNT  = 2'h2;
   localparam logic [1:0]     SFR_EXTRA  = 2'h1;

   // ****************************************************************
   // destination forms
   // ****************************************************************
   typedef enum logic [1:0] {
      IPU_DST_PAIR   = 2'h0,
      IPU_DST_SINGLE = 2'h1,
      IPU_DST_ACC    = 2'h2,
      IPU_DST_FIXED  = 2'h3
   } ipu_dst_t;

   // ****************************************************************
   // issued operation and result carriers
   // ****************************************************************
   typedef struct packed {
      logic                  base_signed;
      logic                  src_signed;
      logic                  src_is_lit;
      ipu_dst_t              dst;
      logic [REG_IDX_W-1:0]  dst_idx;
      logic                  acc_sel;
      logic [WORD_W-1:0]     base_operand_reg;
      logic [WORD_W-1:0]     source_operand_reg;
      logic [LIT_W-1:0]      short_literal;
      logic                  file_is_sfr;
   } ipu_op_t;

   typedef struct packed {
      logic                  wr_lo;
      logic                  wr_hi;
      logic [REG_IDX_W-1:0]  idx_lo;
      logic [REG_IDX_W-1:0]  idx_hi;
      logic [WORD_W-1:0]     data_lo;
      logic [WORD_W-1:0]     data_hi;
      logic                  acc_wr;
      logic                  acc_sel;
      logic [ACC_W-1:0]      acc_data;
   } ipu_res_t;

endpackage : ipu_pkg

// [design/ipu_mult.sv]
// Purpose: combinational 17x17 signed core for all sign modes
// Assumes: raw W-bit operands; the sign flags select zero or sign widening inside
// Notes:   one structure serves all four sign modes

`timescale 1ns/1ps
`default_nettype none

module ipu_mult #(
   parameter int W = ipu_pkg::WORD_W
) (
   input  wire logic [W-1:0]   a,
   input  wire logic           a_signed,
   input  wire logic [W-1:0]   b,
   input  wire logic           b_signed,
   output logic      [2*W-1:0] prod,
   output logic                prod_neg_ext
);
   logic signed [W:0]     a_x;
   logic signed [W:0]     b_x;
   logic signed [2*W+1:0] full;

   // widen by one bit so one signed multiplier covers every mode
   assign a_x          = {a_signed & a[W-1], a};
   assign b_x          = {b_signed & b[W-1], b};
   assign full         = a_x * b_x;
   assign prod         = full[2*W-1:0];
   assign prod_neg_ext = full[2*W+1];
endmodule : ipu_mult

`default_nettype wire

// [design/ipu_top.sv]
// Purpose: integer product unit, one product per issued instruction
// Assumes: decoder supplies read operands and holds issue for one cycle
// Notes:   results leave as register writes from flip-flops
//
// Function
// - four sign modes; full product written to destination and next register
// - any sign-mode product may target a selected accumulator instead
// - unsigned 5-bit literal operand in SU and UU modes, pair or accumulator
// - single-word forms write one register, neighbour untouched, all modes
// - literal forms also offered with a single destination register
// - file operand times default register lands in fixed pair three:two
// - one word, one cycle per form; no status flag changes
// - reading a non-CPU special register costs one more cycle

`timescale 1ns/1ps
`default_nettype none

module ipu_top #(
   parameter int WORD_W = ipu_pkg::WORD_W,
   parameter int ACC_W  = ipu_pkg::ACC_W
) (
   input  wire logic            mclk,
   input  wire logic            rstn,
   input  wire logic            clk_en,
   input  wire logic            issue,
   input  wire ipu_pkg::ipu_op_t op,
   output logic                 busy,
   output logic                 done,
   output ipu_pkg::ipu_res_t    res
);

   // ****************************************************************
   // operand selection
   // ****************************************************************
   logic [WORD_W-1:0]   src_word;
   logic                src_sgn;
   logic [WORD_W:0]     src_live;
   logic [WORD_W:0]     src_held;
   logic [2*WORD_W-1:0] prod;
   logic                prod_neg;

   // literal is always unsigned, zero padded
   // one decode for the live and the replayed operation alike
   function automatic logic [WORD_W:0] pick_src(
      input ipu_pkg::ipu_op_t o
   );
      logic [WORD_W:0] s;
      if (o.src_is_lit) begin
         s = {1'b0, {(WORD_W-ipu_pkg::LIT_W){1'b0}}, o.short_literal};
      end else begin
         s = {o.src_signed, o.source_operand_reg};
      end
      return s;
   endfunction : pick_src

   assign src_live = pick_src(op);
   assign src_word = src_live[WORD_W-1:0];
   assign src_sgn  = src_live[WORD_W];

   // live multiplier shared by all forms; u_mult_held serves the stall replay
   ipu_mult #(
      .W (WORD_W)
   ) u_mult (
      .a            (op.base_operand_reg),
      .a_signed     (op.base_signed),
      .b            (src_word),
      .b_signed     (src_sgn),
      .prod         (prod),
      .prod_neg_ext (prod_neg)
   );

   // ****************************************************************
   // sequencing: one cycle, plus a stall for a non-CPU register read
   // ****************************************************************
   typedef enum logic [1:0] {
      IPU_ST_IDLE  = 2'b01,
      IPU_ST_STALL = 2'b10
   } ipu_state_t;

   // an issue seen during the stall is dropped without trace;
   // the decoder has to hold off until busy falls again
   // limitation: no port reports such a refused issue
   ipu_state_t       state_q;
   ipu_pkg::ipu_op_t held_q;
   logic             fire;
   ipu_pkg::ipu_op_t cur;

   // a stalled file operand is replayed from the held copy
   assign fire = (state_q == IPU_ST_IDLE) ? (issue && !op.file_is_sfr)
                                          : 1'b1;
   assign cur  = (state_q == IPU_ST_IDLE) ? op : held_q;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q <= IPU_ST_IDLE;
         busy    <= 1'b0;
      end else if (clk_en) begin
         case (state_q)
            IPU_ST_IDLE: begin
               if (issue && op.file_is_sfr) begin
                  state_q <= IPU_ST_STALL;
                  busy    <= 1'b1;
               end
            end
            IPU_ST_STALL: begin
               state_q <= IPU_ST_IDLE;
               busy    <= 1'b0;
            end
            default: begin
               state_q <= IPU_ST_IDLE;
               busy    <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // operand capture for the stall
   // ****************************************************************
   // captured on every take; only read while the stall replays
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         held_q <= '0;
      end else if (clk_en && state_q == IPU_ST_IDLE && issue) begin
         held_q <= op;
      end
   end

   // ****************************************************************
   // replayed product
   // ****************************************************************
   // a second multiplier costs area but keeps the operand mux off
   // the live multiply path
   logic [2*WORD_W-1:0] stall_prod;
   logic                stall_neg;

   // replay must decode a literal exactly as the live path does
   assign src_held = pick_src(held_q);

   ipu_mult #(
      .W (WORD_W)
   ) u_mult_held (
      .a            (held_q.base_operand_reg),
      .a_signed     (held_q.base_signed),
      .b            (src_held[WORD_W-1:0]),
      .b_signed     (src_held[WORD_W]),
      .prod         (stall_prod),
      .prod_neg_ext (stall_neg)
   );

   logic [2*WORD_W-1:0] use_prod;
   logic                use_neg;

   assign use_prod = (state_q == IPU_ST_IDLE) ? prod : stall_prod;
   assign use_neg  = (state_q == IPU_ST_IDLE) ? prod_neg : stall_neg;

   // ****************************************************************
   // result write-back
   // ****************************************************************
   function automatic ipu_pkg::ipu_res_t build_res(
      input ipu_pkg::ipu_op_t    o,
      input logic [2*WORD_W-1:0] p,
      input logic                neg
   );
      ipu_pkg::ipu_res_t r;
      r          = '0;
      r.data_lo  = p[WORD_W-1:0];
      r.data_hi  = p[2*WORD_W-1:WORD_W];
      r.idx_lo   = o.dst_idx;
      r.idx_hi   = o.dst_idx + ipu_pkg::IDX_ONE;
      r.acc_sel  = o.acc_sel;
      case (o.dst)
         ipu_pkg::IPU_DST_PAIR: begin
            r.wr_lo = 1'b1;
            r.wr_hi = 1'b1;
         end
         ipu_pkg::IPU_DST_SINGLE: begin
            r.wr_lo = 1'b1;
         end
         ipu_pkg::IPU_DST_ACC: begin
            r.acc_wr   = 1'b1;
            // extend by product sign, not by raw operand bits
            r.acc_data = {{(ACC_W-2*WORD_W){neg}}, p};
         end
         ipu_pkg::IPU_DST_FIXED: begin
            r.wr_lo  = 1'b1;
            r.wr_hi  = 1'b1;
            r.idx_lo = ipu_pkg::FIXED_LO;
            r.idx_hi = ipu_pkg::FIXED_HI;
         end
         default: begin
            r.wr_lo = 1'b0;
         end
      endcase
      return r;
   endfunction : build_res

   // single-destination literal forms share the IPU_DST_SINGLE path
   // no flag output exists at all
   // res cleared outside done so write ports need no extra qualifier
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         res  <= '0;
         done <= 1'b0;
      end else if (clk_en) begin
         done <= fire;
         if (fire) begin
            res <= build_res(cur, use_prod, use_neg);
         end else begin
            res <= '0;
         end
      end
   end

endmodule : ipu_top

`default_nettype wire

// [tb/ipu_chk.sv]
// Purpose: port-level assertions for the product unit
// Assumes: one clock, async active-low reset
// Notes:   attached by bind after the module
`timescale 1ns/1ps
`default_nettype none
module ipu_chk #(
   parameter int WORD_W = 16,
   parameter int ACC_W  = 40
) (
   input wire logic              mclk,
   input wire logic              rstn,
   input wire logic              clk_en,
   input wire logic              issue,
   input wire ipu_pkg::ipu_op_t  op,
   input wire logic              busy,
   input wire logic              done,
   input wire ipu_pkg::ipu_res_t res
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence s_take;
      clk_en && issue && !busy;
   endsequence
   sequence s_fast;
      s_take ##0 !op.file_is_sfr;
   endsequence
   AST_FAST_DONE: assert property (s_fast |=> done)
      else $error("done late");
   AST_SFR_WAIT: assert property (s_take ##0 op.file_is_sfr |=> busy && !done)
      else $error("extra cycle missing");
   AST_SFR_DONE: assert property (busy && clk_en |=> done && !busy)
      else $error("slow done missing");
   AST_FROZEN: assert property (!clk_en |=> $stable(res) && $stable(done))
      else $error("moved while frozen");
   AST_IDLE_ZERO: assert property (!done |-> res == '0)
      else $error("write without done");
   AST_SINGLE: assert property (s_fast ##0 op.dst == ipu_pkg::IPU_DST_SINGLE
      |=> res.wr_lo && !res.wr_hi && !res.acc_wr)
      else $error("single form wrote more");
   AST_FIXED: assert property (s_fast ##0 op.dst == ipu_pkg::IPU_DST_FIXED
      |=> res.wr_hi && res.idx_lo == ipu_pkg::FIXED_LO
      && res.idx_hi == ipu_pkg::FIXED_HI)
      else $error("fixed pair wrong");
   AST_PAIR_IDX: assert property (done && res.wr_hi |-> res.wr_lo
      && res.idx_hi == res.idx_lo + ipu_pkg::IDX_ONE)
      else $error("pair index wrong");
   AST_ACC_ONLY: assert property (done && res.acc_wr |-> !res.wr_lo
      && !res.wr_hi && (res.acc_data[39:32] == '0
      || res.acc_data[39:31] == '1))
      else $error("accumulator write wrong");
endmodule : ipu_chk
bind ipu_top ipu_chk #(.WORD_W(WORD_W), .ACC_W(ACC_W)) i_chk (
   .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .issue(issue),
   .op(op), .busy(busy), .done(done), .res(res));
`default_nettype wire

// [tb/ipu_dec_model.sv]
// Purpose: decoder model issuing product operations
// Assumes: issue is a one-cycle pulse per operation
// Notes:   op is scrambled while idle so stale fields never help
`timescale 1ns/1ps
`default_nettype none
module ipu_dec_model (
   input  wire logic        mclk,
   output logic             clk_en,
   output logic             issue,
   output ipu_pkg::ipu_op_t op
);
   initial begin
      clk_en = 1'b0;
      issue = 1'b0;
      op = '0;
   end
   task automatic send(input ipu_pkg::ipu_op_t o);
      @(posedge mclk);
      clk_en <= 1'b1;
      issue <= 1'b1;
      op <= o;
   endtask : send
   task automatic idle(input logic en);
      @(posedge mclk);
      clk_en <= en;
      issue <= 1'b0;
      op <= ~op;
   endtask : idle
endmodule : ipu_dec_model
`default_nettype wire

// [tb/integer_product_unit_tb_top.sv]
// Purpose: self-checking bench for the product unit
// Assumes: decoder model drives issue, op and clock enable
// Notes:   expected results queued at issue, popped on done
`timescale 1ns/1ps
`default_nettype none
module integer_product_unit_tb_top;
   logic              mclk, rstn, clk_en, issue, busy, done;
   logic [63:0]       rv;
   ipu_pkg::ipu_op_t  o, op;
   ipu_pkg::ipu_res_t res, e;
   ipu_pkg::ipu_res_t exq[$];
   int                err_count, check_count;
   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;
   ipu_dec_model i_dec (.mclk(mclk), .clk_en(clk_en), .issue(issue),
      .op(op));
   ipu_top i_dut (.mclk(mclk), .rstn(rstn), .clk_en(clk_en),
      .issue(issue), .op(op), .busy(busy), .done(done), .res(res));
   task automatic chk(input string n, input logic [63:0] s, x);
      check_count++;
      if (s !== x) begin
         err_count++;
         $display("[ERR] %s exp %h got %h", n, x, s);
      end
   endtask : chk
   function automatic ipu_pkg::ipu_res_t ex(input ipu_pkg::ipu_op_t a);
      logic signed [63:0] p, q;
      ipu_pkg::ipu_res_t  r;
      p = {{48{a.base_signed & a.base_operand_reg[15]}}, a.base_operand_reg};
      q = {{48{a.src_signed & a.source_operand_reg[15]}},
         a.source_operand_reg};
      if (a.src_is_lit) q = {59'h0, a.short_literal};
      p = p * q;
      r = '0;
      r.idx_lo = a.dst == ipu_pkg::IPU_DST_FIXED ? ipu_pkg::FIXED_LO : a.dst_idx;
      r.idx_hi = r.idx_lo + 4'h1;
      r.data_lo = p[15:0];
      r.data_hi = p[31:16];
      r.wr_lo = a.dst != ipu_pkg::IPU_DST_ACC;
      r.wr_hi = a.dst == ipu_pkg::IPU_DST_PAIR || a.dst == ipu_pkg::IPU_DST_FIXED;
      r.acc_wr = a.dst == ipu_pkg::IPU_DST_ACC;
      r.acc_sel = a.acc_sel;
      r.acc_data = p[39:0];
      return r;
   endfunction : ex
   task automatic put(input ipu_pkg::ipu_op_t a);
      exq.push_back(ex(a));
      i_dec.send(a);
   endtask : put
   task automatic end_sim;
      if (err_count == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   always @(posedge mclk) begin
      if (rstn && clk_en && done) begin
         if (exq.size() == 0) chk("spare done", 64'h1, 64'h0);
         else begin
            e = exq.pop_front();
            chk("writes", {res.wr_lo, res.wr_hi, res.acc_wr}, {e.wr_lo, e.wr_hi, e.acc_wr});
            if (e.wr_lo) chk("low", {res.idx_lo, res.data_lo}, {e.idx_lo, e.data_lo});
            if (e.wr_hi) chk("high", {res.idx_hi, res.data_hi}, {e.idx_hi, e.data_hi});
            if (e.acc_wr) chk("acc", {res.acc_sel, res.acc_data}, {e.acc_sel, e.acc_data});
         end
      end
   end
   initial begin
      rstn = 1'b0;
      void'($urandom(9));
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      for (int m = 0; m < 32; m++) begin
         o = '0;
         o.base_signed = m[0];
         o.src_signed = m[1];
         o.dst = ipu_pkg::ipu_dst_t'(m[3:2]);
         o.src_is_lit = m[4];
         o.base_operand_reg = 16'h8000;
         o.source_operand_reg = 16'hFFFF;
         o.short_literal = 5'h1F;
         o.dst_idx = 4'hF;
         o.acc_sel = m[0];
         put(o);
      end
      for (int i = 0; i < 400; i++) begin
         rv = {$urandom, $urandom};
         o = rv[47:0];
         if (rv[63:62] == 2'h0) i_dec.idle(rv[61]);
         else if (o.file_is_sfr) begin
            put(o);
            i_dec.send(~o);
            i_dec.idle(1'b1);
         end else put(o);
      end
      for (int k = 0; k < 20 && exq.size() > 0; k++) i_dec.idle(1'b1);
      chk("left over", 64'(exq.size()), 64'h0);
      end_sim();
   end
endmodule : integer_product_unit_tb_top
`default_nettype wire
